/* File: pkg/timer_params.svh */
// Register map, field positions and reset values of the 16-bit timer/counter
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

`define TC_OFF_COUNT_LOW   8'h00
`define TC_OFF_COUNT_HIGH  8'h04
`define TC_OFF_IRQ_STATUS  8'h08
`define TC_OFF_CONTROL     8'h10
`define TC_OFF_IRQ_ENABLE  8'h14
`define TC_OFF_IRQ_CLEAR   8'h18
`define TC_OFF_PORT_DIR    8'h1C
`define TC_OFF_PORT_DATA   8'h20

`define TC_OVF_BIT         0
`define TC_CTRL_MASK       8'h3F
`define TC_CTRL_RST        8'h00
`define TC_COUNT_RST       16'h0000
`define TC_COUNT_MAX       16'hFFFF
`define TC_DIR_RST         2'h3
`define TC_LATCH_RST       2'h0
`define TC_INSTR_LAST      2'h3
`define TC_PS_DIV1         2'h0
`define TC_PS_DIV2         2'h1
`define TC_PS_DIV4         2'h2
`define TC_PS_DIV8         2'h3
`define TC_PRESC_LAST1     3'h0
`define TC_PRESC_LAST2     3'h1
`define TC_PRESC_LAST4     3'h3
`define TC_PRESC_LAST8     3'h7

`endif

/* File: pkg/timer_pkg.sv */
// Types shared by the timer/counter and its prescaler
package timer_pkg;

  typedef struct packed {
    logic [1:0] unused;
    logic       prescale_select_hi;
    logic       prescale_select_lo;
    logic       crystal_osc_enable;
    logic       sync_disable;
    logic       clock_source_select;
    logic       run_enable;
  } control_s;

  typedef struct packed {
    control_s    ctrl;
    logic [15:0] count;
    logic        ovf;
    logic        irq_en;
    logic        irq;
    logic [1:0]  dir;
    logic [1:0]  port_latch;
    logic [1:0]  pin_out;
    logic [1:0]  pin_oe;
    logic        src_prev;
    logic [1:0]  instr_div;
    logic [1:0]  sync_pipe;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } timer_state_s;

  typedef struct packed {
    logic [2:0] count;
    logic       tick;
  } presc_state_s;

endpackage

/* File: verilog/timer_prescaler.sv */
// Two-bit selectable input prescaler for the timer/counter
`timescale 1ns/1ps
`include "timer_params.svh"

module timer_prescaler
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       edge_in,
  input  wire logic       clear,
  input  wire logic [1:0] select,
  output logic            tick
);

  timer_pkg::presc_state_s state_r;
  timer_pkg::presc_state_s state_nxt;
  logic [2:0]              last;

  always_comb
  begin
    unique case (select)
      `TC_PS_DIV2: last = `TC_PRESC_LAST2;
      `TC_PS_DIV4: last = `TC_PRESC_LAST4;
      `TC_PS_DIV8: last = `TC_PRESC_LAST8;
      `TC_PS_DIV1: last = `TC_PRESC_LAST1;
    endcase
    state_nxt = state_r;
    state_nxt.tick = 1'b0;
    if (clear)
    begin
      state_nxt.count = 3'h0;
    end
    else if (edge_in)
    begin
      if (state_r.count >= last)
      begin
        state_nxt.count = 3'h0;
        state_nxt.tick = 1'b1;
      end
      else
      begin
        state_nxt.count = 3'(state_r.count + 3'h1);
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign tick = state_r.tick;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_clear_zeroes: assert property (clear |=> state_r.count == 3'h0 && !tick)
    else $error("prescaler not cleared");
  a_div_two_pace: assert property (
    select == `TC_PS_DIV2 && !clear && edge_in && state_r.count == 3'h1 |=> tick)
    else $error("divide by two missed its tick");

endmodule

/* File: verilog/timer_counter16.sv */
// 16-bit timer/counter with prescaler, compare reset, APB registers and interrupt
`timescale 1ns/1ps
`include "timer_params.svh"

// Operation
// - Sixteen-bit count in high and low bytes, counts up and wraps to zero.
// - Wrap from FFFFh sets sticky overflow flag until software clears it.
// - Overflow interrupt raised only while overflow interrupt enable is set.
// - Timer mode increments once per instruction cycle, clock divided by four.
// - Counter mode increments on each rising edge of the external input.
// - Counting happens only while the run enable bit zero is set.
// - Either compare unit's special event trigger resets the counter.
// - Crystal enable forces both oscillator pins to inputs reading zero.
// - Prescale field bits 5-4: code 10 divides by four, 01 by two.
// - Counter mode with sync enabled synchronizes prescaled input before counting.
// - Timer mode ignores the sync disable bit.
// - Prescaler ahead of synchronizer, synchronization follows prescaler output.
// - Counter mode takes oscillator input pin if crystal enabled, else clock pin.
// - Synchronized counter mode stops counting in sleep; prescaler keeps counting.
// - Unsynchronized counter mode keeps counting in sleep and can raise interrupt.
// - Compare trigger clears counter; simultaneous register write takes precedence.
// - Writing either count byte clears the prescaler.
// - Control register resets to zero, stopping timer with one-to-one prescale.
module timer_counter16
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  pin_in,
  output logic [1:0]       pin_out,
  output logic [1:0]       pin_oe,
  input  wire logic        cmp1_trigger,
  input  wire logic        cmp2_trigger,
  input  wire logic        sleep,
  output logic             irq
);

  timer_pkg::timer_state_s state_r;
  timer_pkg::timer_state_s state_nxt;
  logic [7:0]              addr;
  logic                    access;
  logic                    wr;
  logic                    wr_low;
  logic                    wr_high;
  logic                    trig;
  logic                    counter_mode;
  logic                    synced;
  logic                    src_level;
  logic                    src_rise;
  logic                    instr_tick;
  logic                    presc_in;
  logic                    presc_tick;
  logic                    presc_clear;
  logic                    inc;
  logic                    ovf_set;
  logic                    ovf_clr;
  logic                    hit;
  logic [31:0]             rd_data;
  logic [1:0]              pins_read;

  assign addr         = {paddr[7:2], 2'h0};
  assign access       = psel && penable;
  assign wr           = access && pwrite && state_r.pready && !state_r.pslverr;
  assign wr_low       = wr && addr == `TC_OFF_COUNT_LOW;
  assign wr_high      = wr && addr == `TC_OFF_COUNT_HIGH;
  assign trig         = cmp1_trigger || cmp2_trigger;
  assign counter_mode = state_r.ctrl.clock_source_select;
  assign synced       = counter_mode && !state_r.ctrl.sync_disable;
  assign presc_clear  = wr_low || wr_high;

  // Pin choice follows the crystal enable
  assign src_level  = state_r.ctrl.crystal_osc_enable ? pin_in[1] : pin_in[0];
  assign src_rise   = src_level && !state_r.src_prev;
  assign instr_tick = !sleep && state_r.instr_div == `TC_INSTR_LAST;
  assign presc_in   = state_r.ctrl.run_enable
                      && (counter_mode ? src_rise : instr_tick);

  timer_prescaler timer_prescaler_i
  (
    .clk_sys (clk_sys),
    .reset   (reset),
    .edge_in (presc_in),
    .clear   (presc_clear),
    .select  ({state_r.ctrl.prescale_select_hi, state_r.ctrl.prescale_select_lo}),
    .tick    (presc_tick)
  );

  // Synchronized path waits on the phase pipeline, unsynchronized path counts at once
  assign inc = state_r.ctrl.run_enable
               && (synced ? state_r.sync_pipe[1] : presc_tick);

  assign ovf_set   = inc && !presc_clear && !trig && state_r.count == `TC_COUNT_MAX;
  assign ovf_clr   = wr && addr == `TC_OFF_IRQ_CLEAR && pwdata[`TC_OVF_BIT];
  assign pins_read = state_r.ctrl.crystal_osc_enable ? 2'h0 : pin_in;

  always_comb
  begin
    hit     = 1'b1;
    rd_data = 32'h0;
    unique case (addr)
      `TC_OFF_COUNT_LOW:  rd_data = {24'h0, state_r.count[7:0]};
      `TC_OFF_COUNT_HIGH: rd_data = {24'h0, state_r.count[15:8]};
      `TC_OFF_IRQ_STATUS: rd_data = {31'h0, state_r.ovf};
      `TC_OFF_CONTROL:    rd_data = {24'h0, state_r.ctrl};
      `TC_OFF_IRQ_ENABLE: rd_data = {31'h0, state_r.irq_en};
      `TC_OFF_IRQ_CLEAR:  rd_data = 32'h0;
      `TC_OFF_PORT_DIR:   rd_data = {30'h0, state_r.dir};
      `TC_OFF_PORT_DATA:  rd_data = {30'h0, pins_read};
      default:            hit = 1'b0;
    endcase
  end

  always_comb
  begin
    state_nxt = state_r;
    state_nxt.pready = 1'b0;
    state_nxt.pslverr = 1'b0;
    if (access && !state_r.pready)
    begin
      state_nxt.pready = 1'b1;
      state_nxt.pslverr = !hit;
      state_nxt.prdata = pwrite ? state_r.prdata : rd_data;
    end

    state_nxt.src_prev = src_level;
    state_nxt.instr_div = sleep ? state_r.instr_div
                                : 2'(state_r.instr_div + 2'h1);
    // Synchronizer is off in sleep
    state_nxt.sync_pipe = {state_r.sync_pipe[0], presc_tick && !sleep};

    // Write beats trigger beats increment
    if (wr_low)
    begin
      state_nxt.count[7:0] = pwdata[7:0];
    end
    else if (wr_high)
    begin
      state_nxt.count[15:8] = pwdata[7:0];
    end
    else if (trig)
    begin
      state_nxt.count = `TC_COUNT_RST;
    end
    else if (inc)
    begin
      state_nxt.count = 16'(state_r.count + 16'h0001);
    end

    state_nxt.ovf = ovf_set || (state_r.ovf && !ovf_clr);

    if (wr && addr == `TC_OFF_CONTROL)
    begin
      state_nxt.ctrl = timer_pkg::control_s'(pwdata[7:0] & `TC_CTRL_MASK);
    end
    if (wr && addr == `TC_OFF_IRQ_ENABLE)
    begin
      state_nxt.irq_en = pwdata[`TC_OVF_BIT];
    end
    if (wr && addr == `TC_OFF_PORT_DIR)
    begin
      state_nxt.dir = pwdata[1:0];
    end
    if (wr && addr == `TC_OFF_PORT_DATA)
    begin
      state_nxt.port_latch = pwdata[1:0];
    end

    state_nxt.irq = state_nxt.ovf && state_nxt.irq_en;
    state_nxt.pin_oe = ~state_nxt.dir & {2{!state_nxt.ctrl.crystal_osc_enable}};
    state_nxt.pin_out = state_nxt.port_latch;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_r <= '0;
      state_r.ctrl <= timer_pkg::control_s'(`TC_CTRL_RST);
      state_r.count <= `TC_COUNT_RST;
      state_r.dir <= `TC_DIR_RST;
      state_r.port_latch <= `TC_LATCH_RST;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign prdata  = state_r.prdata;
  assign pready  = state_r.pready;
  assign pslverr = state_r.pslverr;
  assign pin_out = state_r.pin_out;
  assign pin_oe  = state_r.pin_oe;
  assign irq     = state_r.irq;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_count_wraps: assert property (ovf_set |=> state_r.count == 16'h0000 && state_r.ovf)
    else $error("count did not wrap to zero with overflow");
  a_ovf_sticky: assert property (state_r.ovf && !ovf_clr |=> state_r.ovf [*1])
    else $error("overflow flag dropped without a clear");
  a_irq_gated: assert property (state_r.ovf && !state_r.irq_en |-> !irq)
    else $error("interrupt raised while disabled");
  a_irq_follows: assert property (ovf_set && state_r.irq_en && !wr |=> irq)
    else $error("enabled overflow did not raise interrupt");
  a_instr_pace: assert property (instr_tick |=> !instr_tick [*3])
    else $error("instruction tick faster than one in four");
  a_counter_edge: assert property (
    counter_mode && state_r.ctrl.sync_disable && state_r.ctrl.run_enable
    && !state_r.ctrl.prescale_select_hi && !state_r.ctrl.prescale_select_lo
    && src_rise && !presc_clear |=> presc_tick)
    else $error("external rising edge not passed on");
  a_stopped_hold: assert property (
    !state_r.ctrl.run_enable && !presc_clear && !trig |=> $stable(state_r.count))
    else $error("count moved while stopped");
  a_trig_clears: assert property (trig && !presc_clear |=> state_r.count == 16'h0000)
    else $error("trigger did not clear count");
  a_write_wins: assert property (wr_low && trig |=> state_r.count[7:0] == $past(pwdata[7:0]))
    else $error("trigger beat a register write");
  a_osc_pins_in: assert property (state_r.ctrl.crystal_osc_enable |-> pin_oe == 2'h0)
    else $error("oscillator pins driven while crystal enabled");
  a_sleep_sync: assert property (
    sleep [*3] ##0 synced |-> !inc)
    else $error("synchronized count advanced in sleep");
  a_apb_answer: assert property (access && !pready |=> pready ##1 !pready)
    else $error("register bus answer not one cycle");

  c_overflow:   cover property (ovf_set && state_r.irq_en);
  c_trigger:    cover property (trig && state_r.ctrl.run_enable);
  c_sync_count: cover property (synced && inc);
  c_sleep_ovf:  cover property (sleep && !synced && counter_mode && ovf_set);

endmodule

/* File: testbench/ext_clock_source.sv */
// Behavioural external clock source feeding the timer's two clock pins
`timescale 1ns/1ps

module ext_clock_source
#(
  parameter int HALF = 2
)
(
  input  wire logic       clk_sys,
  input  wire logic       start,
  input  wire logic       sel,
  input  wire logic [7:0] edges,
  output logic [1:0]      pins,
  output logic            busy
);
  logic [7:0] left;
  int         ph;

  initial
  begin
    pins = 2'h0;
    busy = 1'b0;
    left = 8'h00;
    ph = 0;
  end

  // Burst of rising edges on one pin; both pins rest low between bursts
  always @(posedge clk_sys)
    if (start)
    begin
      busy <= 1'b1;
      left <= edges;
      ph <= 0;
    end
    else if (busy && ph == HALF - 1)
    begin
      ph <= 0;
      pins[sel] <= !pins[sel];
      if (pins[sel])
      begin
        left <= left - 8'h01;
        busy <= (left != 8'h01);
      end
    end
    else if (busy)
      ph <= ph + 1;
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench of the 16-bit timer/counter
`timescale 1ns/1ps
`include "timer_params.svh"

`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (e)); end end

module testbench;
  localparam logic [7:0] ctl = `TC_OFF_CONTROL;
  localparam logic [7:0] dat = `TC_OFF_PORT_DATA;
  localparam logic [7:0] sts = `TC_OFF_IRQ_STATUS;
  localparam logic [7:0] ien = `TC_OFF_IRQ_ENABLE;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic        pready, pslverr, irq, busy, rerr;
  logic [1:0]  pin_out, pin_oe, pins;
  wire  [1:0]  pin_in;
  logic        cmp1 = 1'b0;
  logic        cmp2 = 1'b0;
  logic        sleep = 1'b0;
  logic        start = 1'b0;
  logic        sel = 1'b0;
  logic        lvl = 1'b0;
  logic [7:0]  edges = 8'h00;
  logic [15:0] cnt;
  int          n_fail = 0;
  int          num_checks = 0;
  int          ticks = 0;

  assign pin_in = pins | {2{lvl}};

  always #25 clk_sys = ~clk_sys;

  timer_counter16 timer_counter16_i
  (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .pin_in       (pin_in),
    .pin_out      (pin_out),
    .pin_oe       (pin_oe),
    .cmp1_trigger (cmp1),
    .cmp2_trigger (cmp2),
    .sleep        (sleep),
    .irq          (irq)
  );

  ext_clock_source #(.HALF(3)) ext_clock_source_i
  (
    .clk_sys (clk_sys),
    .start   (start),
    .sel     (sel),
    .edges   (edges),
    .pins    (pins),
    .busy    (busy)
  );

  task automatic finish_test();
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    ticks <= ticks + 1;
    if (ticks == 20000)
    begin
      n_fail++;
      finish_test();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic setcnt(input logic [15:0] v);
    wr(`TC_OFF_COUNT_LOW, v[7:0]);
    wr(`TC_OFF_COUNT_HIGH, v[15:8]);
  endtask

  task automatic getcnt();
    rd(`TC_OFF_COUNT_LOW);
    cnt[7:0] = rdat[7:0];
    rd(`TC_OFF_COUNT_HIGH);
    cnt[15:8] = rdat[7:0];
  endtask

  // Burst of edges from the source, then time for the count to settle
  task automatic drive(input logic s, input logic [7:0] n);
    @(posedge clk_sys);
    sel <= s;
    edges <= n;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    @(posedge clk_sys);
    while (busy)
      @(posedge clk_sys);
    repeat (6) @(posedge clk_sys);
    getcnt();
  endtask

  task automatic t_reset();
    rd(ctl);
    `CHK(rdat, 32'h0)
    getcnt();
    `CHK(cnt, 16'h0000)
    `CHK(irq, 1'b0)
    wr(ctl, 8'hFF);
    rd(ctl);
    `CHK(rdat, 32'h3F)
    wr(ctl, 8'h00);
  endtask

  task automatic t_presc();
    for (int i = 0; i < 4; i++)
    begin
      wr(ctl, 8'h07 | 8'(i << 4));
      setcnt(16'h0000);
      drive(1'b0, 8'h10);
      `CHK(cnt, 16'(16 >> i))
    end
    wr(ctl, 8'h27);
    drive(1'b0, 8'h03);
    setcnt(16'h0000);
    drive(1'b0, 8'h01);
    `CHK(cnt, 16'h0000)
    drive(1'b0, 8'h03);
    `CHK(cnt, 16'h0001)
  endtask

  task automatic t_modes();
    wr(ctl, 8'h03);
    setcnt(16'h0000);
    drive(1'b0, 8'h05);
    `CHK(cnt, 16'h0005)
    sleep <= 1'b1;
    drive(1'b0, 8'h05);
    `CHK(cnt, 16'h0005)
    wr(ctl, 8'h07);
    drive(1'b0, 8'h05);
    `CHK(cnt, 16'h000A)
    sleep <= 1'b0;
    wr(ctl, 8'h06);
    drive(1'b0, 8'h04);
    `CHK(cnt, 16'h000A)
    wr(`TC_OFF_PORT_DIR, 8'h00);
    wr(dat, 8'h02);
    lvl <= 1'b1;
    rd(dat);
    `CHK(rdat, 32'h3)
    `CHK(pin_oe, 2'h3)
    `CHK(pin_out, 2'h2)
    wr(ctl, 8'h0F);
    rd(dat);
    `CHK(rdat, 32'h0)
    `CHK(pin_oe, 2'h0)
    lvl <= 1'b0;
    setcnt(16'h0000);
    drive(1'b1, 8'h04);
    `CHK(cnt, 16'h0004)
    drive(1'b0, 8'h04);
    `CHK(cnt, 16'h0004)
  endtask

  task automatic t_ovf();
    wr(ctl, 8'h07);
    setcnt(16'hFFFF);
    drive(1'b0, 8'h01);
    `CHK(cnt, 16'h0000)
    rd(sts);
    `CHK(rdat[0], 1'b1)
    `CHK(irq, 1'b0)
    wr(ien, 8'h01);
    rd(sts);
    `CHK(irq, 1'b1)
    wr(ien, 8'h00);
    rd(sts);
    `CHK(irq, 1'b0)
    wr(ien, 8'h01);
    wr(`TC_OFF_IRQ_CLEAR, 8'h01);
    rd(sts);
    `CHK(rdat[0], 1'b0)
    `CHK(irq, 1'b0)
    setcnt(16'hFFFF);
    drive(1'b0, 8'h01);
    `CHK(irq, 1'b1)
    wr(`TC_OFF_IRQ_CLEAR, 8'h01);
  endtask

  task automatic t_trig();
    wr(ctl, 8'h00);
    setcnt(16'h1234);
    cmp1 <= 1'b1;
    @(posedge clk_sys);
    cmp1 <= 1'b0;
    getcnt();
    `CHK(cnt, 16'h0000)
    setcnt(16'h1234);
    cmp2 <= 1'b1;
    @(posedge clk_sys);
    cmp2 <= 1'b0;
    getcnt();
    `CHK(cnt, 16'h0000)
    cmp1 <= 1'b1;
    wr(`TC_OFF_COUNT_LOW, 8'h5A);
    cmp1 <= 1'b0;
    getcnt();
    `CHK(cnt, 16'h005A)
    rd(sts);
    `CHK(rdat[0], 1'b0)
  endtask

  task automatic t_timer();
    for (int s = 0; s < 2; s++)
    begin
      setcnt(16'h0000);
      wr(ctl, s ? 8'h05 : 8'h01);
      repeat (200) @(posedge clk_sys);
      wr(ctl, 8'h00);
      getcnt();
      `CHK(cnt >= 16'h0030 && cnt <= 16'h0036, 1'b1)
    end
  endtask

  initial
  begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_presc();
    t_modes();
    t_ovf();
    t_trig();
    t_timer();
    rd(8'h3C);
    `CHK(rerr, 1'b1)
    `CHK(rdat, 32'h0)
    wr(ctl, 8'h07);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    finish_test();
  end
endmodule
